// File: hw/adc_acq_pkg.sv
// constants, types and register map of the acquisition control block
// Summary of operation
// - software reads back the programmed gain code from the gain register
// - status word shows fifo empty, half-full, full and conversion busy
// - full status reports a completely filled fifo; further samples are dropped
// - busy is high while a conversion runs and its result is stored
// - mode holds fifo enable, pacer or software trigger, and auto scan
// - mode register reads back the same option bits last written
// - interrupt control write selects the sources of both request lines
// - one readback register returns mode and interrupt control together
// - samples go into the fifo while fifo enable is set; fifo reset discards all and empties it
// - software trigger makes one conversion pulse; result lands in fifo or data register
// - pacer trigger comes from two cascaded divider channels
// - a zero in either pacer divider stops pacer triggers
// - three timer channels, index 0 to 2; byte reads give low eight bits
// - channel zero is user programmable, internal or external clock
// - user channel supports six operating modes, values zero to five
// - software reads the running count of user channel zero
// - stop loads one-shot mode with count zero; output then stays high
// - gain resets to unity; codes select 1/2/4/8 or 1/10/100/1000
// - channel register picks one of 32 inputs, or last scan channel
// - line one: off, end of conversion, half-full; line two: off, pacer, external
package adc_acq_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_GAIN = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_IRQC = 8'h10;
  localparam logic [7:0] OFS_RDBK = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_CMD = 8'h1C;
  localparam logic [7:0] OFS_DIV1 = 8'h20;
  localparam logic [7:0] OFS_DIV2 = 8'h24;
  localparam logic [7:0] OFS_CCFG = 8'h28;
  localparam logic [7:0] OFS_CVAL = 8'h2C;
  localparam logic [7:0] OFS_TBYTE0 = 8'h30;
  localparam logic [7:0] OFS_TBYTE1 = 8'h34;
  localparam logic [7:0] OFS_TBYTE2 = 8'h38;
  // field positions
  localparam int MODE_FIFO_BIT = 0;
  localparam int MODE_PACER_BIT = 1;
  localparam int MODE_SCAN_BIT = 2;
  localparam int CMD_FIFO_RST_BIT = 0;
  localparam int CMD_SOFT_TRIG_BIT = 1;
  localparam int CMD_CNT_STOP_BIT = 2;
  localparam int STS_EMPTY_BIT = 0;
  localparam int STS_HALF_BIT = 1;
  localparam int STS_FULL_BIT = 2;
  localparam int STS_BUSY_BIT = 3;
  localparam int IRQ1_LSB = 0;
  localparam int IRQ2_LSB = 2;
  localparam int RDBK_IRQ_LSB = 4;
  localparam int CCFG_EXT_BIT = 3;
  // reset values
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [3:0] IRQC_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [4:0] LAST_INPUT = 5'h1F;
  // sample fifo geometry
  localparam int FIFO_AW = 10;
  localparam logic [10:0] FIFO_DEPTH = 11'h400;
  localparam logic [10:0] FIFO_HALF = 11'h200;
  typedef enum logic [1:0] {
    IRQ1_OFF = 2'h0, IRQ1_EOC = 2'h1, IRQ1_HALF = 2'h2
  } irq1_src_e;
  typedef enum logic [1:0] {
    IRQ2_OFF = 2'h0, IRQ2_PACER = 2'h1, IRQ2_EXT = 2'h2
  } irq2_src_e;
  typedef enum logic [2:0] {
    CM_TERM = 3'h0, CM_ONESHOT = 3'h1, CM_RATE = 3'h2,
    CM_SQUARE = 3'h3, CM_SWSTROBE = 3'h4, CM_HWSTROBE = 3'h5
  } cnt_mode_e;
  typedef enum logic [2:0] {
    CV_IDLE = 3'b001, CV_WAIT = 3'b010, CV_STORE = 3'b100
  } conv_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
  typedef struct packed {
    logic [4:0] chan;
    logic [15:0] data;
  } sample_s;
endpackage

// File: hw/timer_channel.sv
// one down-counting timer channel with six operating modes
module timer_channel
  import adc_acq_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // count control
  input wire logic i_tick,
  input wire logic i_gate,
  input wire logic i_load,
  input wire logic [15:0] i_count,
  input wire cnt_mode_e i_mode,
  // results
  output logic o_out,
  output logic o_term,
  output logic [15:0] o_count
);
  logic [15:0] reload_r;
  logic armed_r;
  logic gate_q_r;
  logic gate_rise;
  logic hw_start;
  logic gate_ok;

  // modes 1 and 5 start on a gate edge, others count while gate is high
  assign hw_start = (i_mode == CM_ONESHOT) || (i_mode == CM_HWSTROBE);
  assign gate_rise = i_gate & ~gate_q_r;
  assign gate_ok = hw_start | i_gate;

  // counting, reload and output waveform
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      reload_r <= 16'h0000;
      o_count <= 16'h0000;
      armed_r <= 1'b0;
      gate_q_r <= 1'b0;
      o_out <= 1'b1;
      o_term <= 1'b0;
    end else begin
      gate_q_r <= i_gate;
      o_term <= 1'b0;
      if (i_load) begin
        reload_r <= i_count;
        o_count <= i_count;
        armed_r <= (i_count != 16'h0000) && !hw_start;
        o_out <= (i_mode != CM_TERM) || (i_count == 16'h0000);
      end else if (gate_rise && hw_start && reload_r != 16'h0000) begin
        o_count <= reload_r;
        armed_r <= 1'b1;
        o_out <= (i_mode != CM_ONESHOT);
      end else if (i_tick && armed_r && gate_ok) begin
        case (i_mode)
          CM_TERM, CM_ONESHOT: begin
            o_count <= o_count - 16'h0001;
            if (o_count == 16'h0001) begin
              o_out <= 1'b1;
              armed_r <= 1'b0;
              o_term <= 1'b1;
            end
          end
          CM_RATE: begin
            o_out <= (o_count != 16'h0002);
            o_count <= (o_count == 16'h0001) ? reload_r : o_count - 16'h0001;
            o_term <= (o_count == 16'h0001);
          end
          CM_SQUARE: begin
            o_count <= (o_count == 16'h0001) ? reload_r : o_count - 16'h0001;
            o_out <= (o_count == 16'h0001) || (o_count > {1'b0, reload_r[15:1]} + 16'h0001);
            o_term <= (o_count == 16'h0001);
          end
          CM_SWSTROBE, CM_HWSTROBE: begin
            o_count <= o_count - 16'h0001;
            o_out <= (o_count != 16'h0001);
            if (o_count == 16'h0001) begin
              armed_r <= 1'b0;
              o_term <= 1'b1;
            end
          end
          default: armed_r <= 1'b0;
        endcase
      end else if (!armed_r) begin
        o_out <= o_out | (i_mode != CM_TERM); // strobe lasts one clock cycle
      end
    end
  end
endmodule

// File: hw/adc_acq_ctrl.sv
// acquisition control: settings, triggers, sample fifo, timers, readback
//
// Implementation choices: the register addresses and the address-and-strobe port.
module adc_acq_ctrl
  import adc_acq_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port
  input wire bus_req_s i_bus,
  output logic [15:0] o_rdata,
  // converter
  output logic o_conv_start,
  output logic [4:0] o_conv_channel,
  output logic [1:0] o_conv_gain,
  input wire logic i_conv_done,
  input wire logic [15:0] i_conv_data,
  // user counter pins
  input wire logic i_cnt_ext_clk,
  input wire logic i_cnt_gate,
  output logic o_cnt_out,
  // interrupt request lines
  input wire logic i_ext_irq,
  output logic o_irq_line_one,
  output logic o_irq_line_two
);
  // address compare, used by every write-side decoder
  function automatic logic hit(input bus_req_s b, input logic [7:0] ofs);
    hit = (b.addr == ofs);
  endfunction

  // fifo pointer step with wrap
  function automatic logic [FIFO_AW-1:0] step(input logic [FIFO_AW-1:0] p);
    step = p + {{(FIFO_AW-1){1'b0}}, 1'b1};
  endfunction

  // settings
  logic [1:0] gain_range_code_r;
  logic [2:0] mode_r;
  logic [4:0] input_channel_select_r;
  logic [3:0] irq_control_value_r;
  logic [15:0] div1_r;
  logic [15:0] div2_r;
  cnt_mode_e cnt_mode_r;
  logic cnt_ext_r;
  // command and access strobes
  logic wr_cmd;
  logic fifo_clear;
  logic soft_trig;
  logic cnt_stop;
  logic rd_data;
  // timers
  logic ld0, ld1, ld2;
  logic [15:0] ld0_val, ld1_val, ld2_val;
  logic tick0;
  logic ext_q_r;
  logic term1, term2;
  logic [15:0] cnt0, cnt1, cnt2;
  logic pacer_tick;
  // conversion
  conv_state_e conv_state_r;
  conv_state_e conv_state_nxt;
  logic trig;
  logic busy_r;
  logic [15:0] conv_data_r;
  logic [4:0] scan_ch_r;
  logic [4:0] conv_ch;
  logic store;
  // fifo
  sample_s fifo_mem [0:FIFO_DEPTH-1];
  logic [FIFO_AW-1:0] wr_ptr_r;
  logic [FIFO_AW-1:0] rd_ptr_r;
  logic [10:0] level_r;
  logic [10:0] level_nxt;
  logic push, pop;
  logic empty_r, half_r, full_r;
  sample_s hold_r;
  logic fifo_en, pacer_sel, scan_en;

  assign fifo_en = mode_r[MODE_FIFO_BIT];
  assign pacer_sel = mode_r[MODE_PACER_BIT];
  assign scan_en = mode_r[MODE_SCAN_BIT];

  // command register strobes
  assign wr_cmd = i_bus.wr && hit(i_bus, OFS_CMD);
  assign fifo_clear = wr_cmd && i_bus.wdata[CMD_FIFO_RST_BIT];
  assign soft_trig = wr_cmd && i_bus.wdata[CMD_SOFT_TRIG_BIT];
  assign cnt_stop = wr_cmd && i_bus.wdata[CMD_CNT_STOP_BIT];
  assign rd_data = i_bus.rd && hit(i_bus, OFS_DATA);

  // gain and input channel settings
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_range_code_r <= GAIN_RST;
      input_channel_select_r <= CHAN_RST;
    end else if (i_bus.wr) begin
      if (hit(i_bus, OFS_GAIN)) begin
        gain_range_code_r <= i_bus.wdata[1:0];
      end
      if (hit(i_bus, OFS_CHAN)) begin
        input_channel_select_r <= i_bus.wdata[4:0];
      end
    end
  end

  // trigger mode and interrupt source selection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= MODE_RST;
      irq_control_value_r <= IRQC_RST;
    end else if (i_bus.wr) begin
      if (hit(i_bus, OFS_MODE)) begin
        mode_r <= i_bus.wdata[2:0];
      end
      if (hit(i_bus, OFS_IRQC)) begin
        irq_control_value_r <= i_bus.wdata[3:0];
      end
    end
  end

  // pacer dividers and user counter configuration
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div1_r <= DIV_RST;
      div2_r <= DIV_RST;
      cnt_mode_r <= CM_TERM;
      cnt_ext_r <= 1'b0;
    end else begin
      if (ld1) begin
        div1_r <= ld1_val;
      end
      if (ld2) begin
        div2_r <= ld2_val;
      end
      if (cnt_stop) begin
        cnt_mode_r <= CM_ONESHOT;
      end else if (i_bus.wr && hit(i_bus, OFS_CCFG)) begin
        cnt_mode_r <= (i_bus.wdata[2:0] > 3'h5) ? CM_TERM : cnt_mode_e'(i_bus.wdata[2:0]);
        cnt_ext_r <= i_bus.wdata[CCFG_EXT_BIT];
      end
    end
  end

  // timer loads from word registers and byte ports
  always_comb begin
    ld0 = cnt_stop || (i_bus.wr && (hit(i_bus, OFS_CVAL) || hit(i_bus, OFS_TBYTE0)));
    ld1 = i_bus.wr && (hit(i_bus, OFS_DIV1) || hit(i_bus, OFS_TBYTE1));
    ld2 = i_bus.wr && (hit(i_bus, OFS_DIV2) || hit(i_bus, OFS_TBYTE2));
    ld0_val = hit(i_bus, OFS_CVAL) ? i_bus.wdata : {8'h00, i_bus.wdata[7:0]};
    ld1_val = hit(i_bus, OFS_DIV1) ? i_bus.wdata : {8'h00, i_bus.wdata[7:0]};
    ld2_val = hit(i_bus, OFS_DIV2) ? i_bus.wdata : {8'h00, i_bus.wdata[7:0]};
    if (cnt_stop) begin
      ld0_val = 16'h0000;
    end
  end

  // external clock edge for the user counter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_q_r <= 1'b0;
    end else begin
      ext_q_r <= i_cnt_ext_clk;
    end
  end
  assign tick0 = cnt_ext_r ? (i_cnt_ext_clk & ~ext_q_r) : 1'b1;

  // user counter, channel zero
  timer_channel u_cnt0 (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(tick0),
    .i_gate(i_cnt_gate),
    .i_load(ld0),
    .i_count(ld0_val),
    .i_mode(cnt_stop ? CM_ONESHOT : cnt_mode_r),
    .o_out(o_cnt_out),
    .o_term(),
    .o_count(cnt0)
  );

  // first pacer divider, on the block clock
  timer_channel u_cnt1 (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(1'b1),
    .i_gate(1'b1),
    .i_load(ld1),
    .i_count(ld1_val),
    .i_mode(CM_RATE),
    .o_out(),
    .o_term(term1),
    .o_count(cnt1)
  );

  // second pacer divider, cascaded on the first
  timer_channel u_cnt2 (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(term1),
    .i_gate(1'b1),
    .i_load(ld2),
    .i_count(ld2_val),
    .i_mode(CM_RATE),
    .o_out(),
    .o_term(term2),
    .o_count(cnt2)
  );

  // zero in either divider silences the pacer
  assign pacer_tick = term2 && (div1_r != DIV_RST) && (div2_r != DIV_RST);

  // trigger source by mode, ignored while a conversion is running
  assign trig = !busy_r && (pacer_sel ? pacer_tick : soft_trig);
  assign conv_ch = scan_en ? scan_ch_r : input_channel_select_r;
  assign store = (conv_state_r == CV_STORE);

  // conversion sequence
  always_comb begin
    conv_state_nxt = conv_state_r;
    case (conv_state_r)
      CV_IDLE: begin
        if (trig) begin
          conv_state_nxt = CV_WAIT;
        end
      end
      CV_WAIT: begin
        if (i_conv_done) begin
          conv_state_nxt = CV_STORE;
        end
      end
      CV_STORE: conv_state_nxt = CV_IDLE;
      default: conv_state_nxt = CV_IDLE;
    endcase
  end

  // state, busy flag and converter drive
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      conv_state_r <= CV_IDLE;
      busy_r <= 1'b0;
      o_conv_start <= 1'b0;
      o_conv_channel <= CHAN_RST;
      o_conv_gain <= GAIN_RST;
      conv_data_r <= 16'h0000;
    end else begin
      conv_state_r <= conv_state_nxt;
      busy_r <= (conv_state_nxt != CV_IDLE);
      o_conv_start <= (conv_state_r == CV_IDLE) && trig;
      o_conv_gain <= gain_range_code_r;
      if (conv_state_r == CV_IDLE) begin
        o_conv_channel <= conv_ch;
      end
      if (conv_state_r == CV_WAIT && i_conv_done) begin
        conv_data_r <= i_conv_data;
      end
    end
  end

  // auto scan walks 0 up to the set last channel
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scan_ch_r <= CHAN_RST;
    end else if (i_bus.wr && (hit(i_bus, OFS_CHAN) || hit(i_bus, OFS_MODE))) begin
      scan_ch_r <= CHAN_RST;
    end else if (store && scan_en) begin
      scan_ch_r <= (scan_ch_r >= input_channel_select_r) ? CHAN_RST : scan_ch_r + 5'h01;
    end
  end

  // fifo traffic; a full fifo drops the sample
  assign push = store && fifo_en && !full_r;
  assign pop = rd_data && fifo_en && !empty_r;

  always_comb begin
    level_nxt = level_r;
    if (fifo_clear) begin
      level_nxt = 11'h000;
    end else if (push && !pop) begin
      level_nxt = level_r + 11'h001;
    end else if (pop && !push) begin
      level_nxt = level_r - 11'h001;
    end
  end

  // pointers and flags
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= 11'h000;
      empty_r <= 1'b1;
      half_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
      empty_r <= (level_nxt == 11'h000);
      half_r <= (level_nxt >= FIFO_HALF);
      full_r <= (level_nxt == FIFO_DEPTH);
      if (fifo_clear) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= step(wr_ptr_r);
        end
        if (pop) begin
          rd_ptr_r <= step(rd_ptr_r);
        end
      end
    end
  end

  // fifo storage
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= '{chan: o_conv_channel, data: conv_data_r};
    end
  end

  // data register used while the fifo is off
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_r <= '0;
    end else if (store && !fifo_en) begin
      hold_r <= '{chan: o_conv_channel, data: conv_data_r};
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        OFS_DATA: o_rdata <= fifo_en ? fifo_mem[rd_ptr_r].data : hold_r.data;
        OFS_CHAN: o_rdata <= {11'h000, input_channel_select_r};
        OFS_GAIN: o_rdata <= {14'h0000, gain_range_code_r};
        OFS_MODE: o_rdata <= {13'h0000, mode_r};
        OFS_IRQC: o_rdata <= {12'h000, irq_control_value_r};
        OFS_RDBK: o_rdata <= {8'h00, irq_control_value_r, 1'b0, mode_r};
        OFS_STAT: o_rdata <= {12'h000, busy_r, full_r, half_r, empty_r};
        OFS_DIV1: o_rdata <= div1_r;
        OFS_DIV2: o_rdata <= div2_r;
        OFS_CCFG: o_rdata <= {12'h000, cnt_ext_r, cnt_mode_r};
        OFS_CVAL: o_rdata <= cnt0;
        OFS_TBYTE0: o_rdata <= {8'h00, cnt0[7:0]};
        OFS_TBYTE1: o_rdata <= {8'h00, cnt1[7:0]};
        OFS_TBYTE2: o_rdata <= {8'h00, cnt2[7:0]};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // request lines from the selected sources
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_line_one <= 1'b0;
      o_irq_line_two <= 1'b0;
    end else begin
      case (irq1_src_e'(irq_control_value_r[IRQ1_LSB +: 2]))
        IRQ1_EOC: o_irq_line_one <= store;
        IRQ1_HALF: o_irq_line_one <= half_r;
        default: o_irq_line_one <= 1'b0;
      endcase
      case (irq2_src_e'(irq_control_value_r[IRQ2_LSB +: 2]))
        IRQ2_PACER: o_irq_line_two <= pacer_tick;
        IRQ2_EXT: o_irq_line_two <= i_ext_irq;
        default: o_irq_line_two <= 1'b0;
      endcase
    end
  end
endmodule

// File: verification/adc_acq_ctrl_monitor.sv
// port assertions for the acquisition control block
module adc_acq_ctrl_monitor
  import adc_acq_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port
  input wire bus_req_s i_bus,
  input wire logic [15:0] o_rdata,
  // converter and counter
  input wire logic o_conv_start,
  input wire logic i_conv_done,
  input wire logic o_cnt_out,
  // interrupt lines
  input wire logic i_ext_irq,
  input wire logic o_irq_line_one,
  input wire logic o_irq_line_two
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [3:0] irqc_r;
  // shadow of the interrupt source selection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irqc_r <= 4'h0;
    end else if (i_bus.wr && i_bus.addr == OFS_IRQC) begin
      irqc_r <= i_bus.wdata[3:0];
    end
  end
  sequence wr_at(logic [7:0] a);
    i_bus.wr && i_bus.addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    i_bus.rd && i_bus.addr == a;
  endsequence
  rdata_idle_a:
  assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
  gain_back_a:
  assert property (wr_at(OFS_GAIN) ##1 rd_at(OFS_GAIN) |=>
    o_rdata == {14'h0000, $past(i_bus.wdata[1:0], 2)}) else $error("gain readback wrong");
  mode_back_a:
  assert property (wr_at(OFS_MODE) ##1 rd_at(OFS_RDBK) |=>
    o_rdata[2:0] == $past(i_bus.wdata[2:0], 2) && o_rdata[7:4] == irqc_r)
    else $error("combined readback wrong");
  start_once_a:
  assert property (o_conv_start |=> !o_conv_start) else $error("start pulse too long");
  busy_set_a:
  assert property (o_conv_start ##1 rd_at(OFS_STAT) |=> o_rdata[STS_BUSY_BIT])
    else $error("busy missing during conversion");
  busy_clr_a:
  assert property (i_conv_done ##2 rd_at(OFS_STAT) |=> !o_rdata[STS_BUSY_BIT])
    else $error("busy stuck after store");
  cnt_stop_a:
  assert property (i_bus.wr && i_bus.addr == OFS_CMD && i_bus.wdata[CMD_CNT_STOP_BIT] |->
    ##[1:2] o_cnt_out [*4]) else $error("counter output not high after stop");
  eoc_pulse_a:
  assert property (i_conv_done && irqc_r[1:0] == IRQ1_EOC |->
    ##2 o_irq_line_one ##1 !o_irq_line_one) else $error("end of conversion pulse wrong");
  ext_follow_a:
  assert property (irqc_r[3:2] == IRQ2_EXT && $past(irqc_r[3:2]) == IRQ2_EXT |->
    o_irq_line_two == $past(i_ext_irq)) else $error("external request not followed");
endmodule
bind adc_acq_ctrl adc_acq_ctrl_monitor i_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_conv_start(o_conv_start), .i_conv_done(i_conv_done),
  .o_cnt_out(o_cnt_out), .i_ext_irq(i_ext_irq), .o_irq_line_one(o_irq_line_one),
  .o_irq_line_two(o_irq_line_two));

// File: verification/adc_conv_model.sv
// converter model answering each start after a short or long delay
module adc_conv_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // converter side
  input wire logic i_start,
  input wire logic i_slow,
  output logic o_done,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  logic [15:0] last_r;
  // count the conversion time down, then show one result for a cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 0;
      o_done <= 1'b0;
      o_data <= 16'h0000;
      last_r <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      o_data <= ~last_r; // result lines do not hold after done
      if (i_start) begin
        wait_q <= i_slow ? 3 + $urandom_range(17) : 3;
      end else if (wait_q == 1) begin
        o_done <= 1'b1;
        o_data <= last_r + 16'h1235;
        last_r <= last_r + 16'h1235;
        wait_q <= 0;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule

// File: verification/tb_adc_acq_ctrl.sv
// self-checking bench for the acquisition control block
module tb_adc_acq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_acq_pkg::*;
  logic clk, rst, conv_start, conv_done, cnt_ext, cnt_gate, cnt_out, ext_irq, irq1, irq2, slow;
  logic [15:0] rdata, conv_data, v1, v2, v3, k;
  logic [4:0] conv_chan;
  logic [1:0] conv_gain;
  bus_req_s bus;
  int fail_count, n_compared, done_cnt;
  logic [2:0] mode_m;
  logic [15:0] dreg_m, g, ic;
  logic [15:0] q[$];

  adc_acq_ctrl i_dut (.i_ref_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
    .o_conv_start(conv_start), .o_conv_channel(conv_chan), .o_conv_gain(conv_gain),
    .i_conv_done(conv_done), .i_conv_data(conv_data), .i_cnt_ext_clk(cnt_ext),
    .i_cnt_gate(cnt_gate), .o_cnt_out(cnt_out), .i_ext_irq(ext_irq),
    .o_irq_line_one(irq1), .o_irq_line_two(irq2));
  adc_conv_model i_conv (.i_ref_clk(clk), .i_rst(rst), .i_start(conv_start), .i_slow(slow),
    .o_done(conv_done), .o_data(conv_data));

  // reference: results go to the fifo queue or the data register
  always @(posedge clk) begin
    if (conv_done) begin
      done_cnt++;
      if (!mode_m[0]) dreg_m = conv_data;
      else if (q.size() < 1024) q.push_back(conv_data);
    end
  end
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic void note(input logic [7:0] a, input logic [15:0] d);
    if (a == OFS_MODE) mode_m = d[2:0];
    if (a == OFS_CMD && d[0]) q.delete();
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    note(a, d);
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    check(v, e);
  endtask
  // write then read at once in the next cycle
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d, input logic [7:0] ra,
    input logic [15:0] e);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    note(a, d);
    @(posedge clk);
    bus <= '{ra, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic wait_done(input int n, input int lim);
    int t;
    t = 0;
    while (done_cnt < n && t < lim) begin
      @(posedge clk);
      #1 t++;
    end
    if (done_cnt < n) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  function automatic logic [15:0] stat_m();
    return {13'h0000, q.size() == 1024, q.size() >= 512, q.size() == 0};
  endfunction
  task automatic soft_conv();
    int n;
    n = done_cnt;
    wr(OFS_CMD, 16'h0002);
    rdchk(OFS_STAT, stat_m() | 16'h0008);
    wait_done(n + 1, 100);
    rdchk(OFS_STAT, stat_m());
  endtask

  // main sequence
  initial begin
    void'($urandom(58));
    rst = 1'b1;
    bus = '0;
    {cnt_ext, cnt_gate, ext_irq, slow} = 4'h0;
    mode_m = 3'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFS_RDBK, 16'h0000);
    rdchk(OFS_STAT, 16'h0001);
    rdchk(8'hFC, 16'h0000);
    rdchk(OFS_GAIN, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      g = 16'(i % 4);
      wrrd(OFS_GAIN, g, OFS_GAIN, g);
      check({14'h0000, conv_gain}, g);
    end
    for (int i = 0; i < 9; i++) begin
      ic = 16'(((i / 3) % 3) * 4 + i % 3);
      wr(OFS_IRQC, ic);
      wrrd(OFS_MODE, 16'(i % 8), OFS_RDBK, (ic << 4) | 16'(i % 8));
      rdchk(OFS_MODE, 16'(i % 8));
    end
    // software triggers, fifo off, slow converter
    wr(OFS_MODE, 16'h0000);
    wr(OFS_IRQC, 16'h0001);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      g = 16'($urandom_range(31));
      wr(OFS_CHAN, g);
      soft_conv();
      check({11'h000, conv_chan}, g);
      rdchk(OFS_DATA, dreg_m);
    end
    // auto scan over inputs 0 to 2, wrapping after the last
    wr(OFS_MODE, 16'h0004);
    wr(OFS_CHAN, 16'h0002);
    for (int i = 1; i < 4; i++) begin
      soft_conv();
      check({11'h000, conv_chan}, 16'(i % 3));
    end
    // fifo on: store three, read the first, discard the rest
    wr(OFS_MODE, 16'h0001);
    wr(OFS_CMD, 16'h0001);
    repeat (3) soft_conv();
    rdchk(OFS_STAT, stat_m());
    rdchk(OFS_DATA, q.pop_front());
    wr(OFS_CMD, 16'h0001);
    rdchk(OFS_STAT, 16'h0001);
    // pacer fills the fifo past full, then is stopped by a zero divider
    slow <= 1'b0;
    wr(OFS_IRQC, 16'h0006);
    wr(OFS_DIV1, 16'h0005);
    wr(OFS_TBYTE2, 16'h0105);
    rdchk(OFS_DIV2, 16'h0005);
    wr(OFS_MODE, 16'h0003);
    wait_done(done_cnt + 1030, 40000);
    wr(OFS_DIV1, 16'h0000);
    repeat (30) @(posedge clk);
    k = 16'h0000;
    repeat (100) begin
      @(posedge clk);
      #1 k = k + 16'(conv_start);
    end
    check(k, 16'h0000);
    check({15'h0000, irq1}, 16'h0001);
    rdchk(OFS_STAT, 16'h0006);
    for (int i = 0; i < 1024; i++) begin
      if (i == 1 || i == 512 || i == 513) rdchk(OFS_STAT, stat_m());
      rdchk(OFS_DATA, q.pop_front());
    end
    rdchk(OFS_STAT, 16'h0001);
    // external request source on line two
    wr(OFS_IRQC, 16'h0008);
    repeat (20) begin
      @(posedge clk);
      ext_irq <= 1'($urandom_range(1));
    end
    // user counter: every mode, odd modes on the external clock
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CCFG, 16'(i + (i % 2) * 8));
      wr(OFS_CVAL, 16'h0064);
      repeat (10) begin
        @(posedge clk);
        cnt_ext <= ~cnt_ext;
        cnt_gate <= 1'($urandom_range(1));
      end
    end
    @(posedge clk);
    cnt_gate <= 1'b1;
    wr(OFS_CCFG, 16'h0000);
    wr(OFS_CVAL, 16'h0064);
    rd(OFS_CVAL, v1);
    rd(OFS_CVAL, v2);
    rd(OFS_TBYTE0, v3);
    check(v1 - v2, 16'h0002);
    check(v3, {8'h00, v2[7:0] - 8'h02});
    wr(OFS_CMD, 16'h0004);
    repeat (4) @(posedge clk);
    rdchk(OFS_CVAL, 16'h0000);
    check({15'h0000, cnt_out}, 16'h0001);
    tally_and_finish();
  end
endmodule
